/* rtl/ulsd_pkg.sv */
/*
  Constants, state types and a helper function for the line-state and speed-detect block.
  Assumes a single 10 MHz system clock and line inputs that are asynchronous digital levels, synchronised before classifying.
*/
// Operation
// R01: Repeat traffic between host and peripheral pairs
// R02: D- pull-up at attach selects low speed
// R03: D+ pull-up at attach selects full speed
// R04: HS peripheral chirps K during reset SE0
// R05: HS host answers chirp with KJ pairs
// R06: Peripheral terminates after three KJ pairs
// R07: Switch own terminations to mirror both ends
// R08: LS/FS end of packet is SE0
// R09: HS end of packet is seven ones
// R10: HS SE0 between packets is idle
// R11: J follows pull-up polarity at LS/FS
// R12: HS J positive, K negative differential
// R13: K is inverse of J encoding
// R14: SE0 is both lines low
// R15: Never repeat SE1 to other side
// R16: Idle is J at LS/FS, none at HS
// R17: First transition from idle sets direction
// R18: Synchronise line inputs before classifying
package ulsd_pkg;

  //--------------------------------------------------------------------
  // Line states and speeds
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {LS_SE0, LS_J, LS_K, LS_SE1} ulsd_line_e;
  typedef enum logic [1:0] {SPD_NONE, SPD_LOW, SPD_FULL, SPD_HIGH} ulsd_speed_e;

  //--------------------------------------------------------------------
  // Counts
  //--------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;  // System clock rate
  localparam int unsigned IDLE_TIMEOUT_US = 3;           // Long idle that releases direction
  localparam int unsigned IDLE_CYC        = (IDLE_TIMEOUT_US * CLK_HZ) / 1_000_000;
  localparam logic [7:0]  IDLE_CYC_T      = IDLE_CYC[7:0];
  localparam logic [2:0]  CHIRP_PAIRS_MIN = 3'h3;        // KJ pairs before HS terminations
  localparam logic [2:0]  HS_ONES_EOP     = 3'h7;        // Ones run ending an HS packet
  localparam logic [1:0]  SYNC_STAGES_RST = 2'h0;        // Synchroniser reset value

  //--------------------------------------------------------------------
  // Classify a pin pair for the current speed
  //--------------------------------------------------------------------
  function automatic ulsd_line_e ulsd_classify(input logic dp, input logic dm, input ulsd_speed_e spd);
    ulsd_line_e r;
    r = LS_SE0;
    if (dp && dm) begin
      r = LS_SE1;                         // R15
    end else if (!dp && !dm) begin
      r = LS_SE0;                         // R14
    end else if (spd == SPD_LOW) begin
      r = dm ? LS_J : LS_K;               // R11 R13
    end else begin
      r = dp ? LS_J : LS_K;               // R11 R12 R13
    end
    return r;
  endfunction

endpackage

/* rtl/ulsd_if.sv */
/*
  Interface carrying both synchronised pin pairs (host and peripheral) between the sampler and the main logic.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface ulsd_if;
  logic host_side_dplus;    // Synchronised host pair D+
  logic host_side_dminus;   // Synchronised host pair D-
  logic periph_side_dplus;  // Synchronised peripheral pair D+
  logic periph_side_dminus; // Synchronised peripheral pair D-
  modport src (output host_side_dplus, host_side_dminus, periph_side_dplus, periph_side_dminus);
  modport dst (input  host_side_dplus, host_side_dminus, periph_side_dplus, periph_side_dminus);
endinterface

/* rtl/ulsd_sync.sv */
/*
  Two-stage synchroniser for the four line inputs.
  Assumes raw pins may change at any time relative to the clock.
*/
`timescale 1ns/1ps
module ulsd_sync
  import ulsd_pkg::*;
(
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_rst_n,    // Async reset, low active
  input  wire logic [3:0] i_pins, // Raw {hd+,hd-,pd+,pd-}
  ulsd_if.src       o_sync      // Synchronised pins
);
  //--------------------------------------------------------------------
  // Two flops; first stage feeds only the second
  //--------------------------------------------------------------------
  logic [3:0] meta_q;   // First stage
  logic [3:0] stab_q;   // Second stage

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      stab_q <= '0;
    end else begin
      meta_q <= i_pins;   // R18
      stab_q <= meta_q;   // R18
    end
  end

  assign o_sync.host_side_dplus    = stab_q[3];
  assign o_sync.host_side_dminus   = stab_q[2];
  assign o_sync.periph_side_dplus  = stab_q[1];
  assign o_sync.periph_side_dminus = stab_q[0];
endmodule

/* rtl/ulsd_top.sv */
/*
  Line-state classification, speed tracking, direction control and repeat logic.
  Assumes the pins are open-style: outputs act only while their enable is high, pull-ups external.
*/
`timescale 1ns/1ps
module ulsd_top
  import ulsd_pkg::*;
(
  input  wire logic i_sys_clk,              // System clock, 10 MHz
  input  wire logic i_rst_n,                // Async reset, low active
  input  wire logic i_host_side_dplus,      // Host pair D+ level
  input  wire logic i_host_side_dminus,     // Host pair D- level
  input  wire logic i_periph_side_dplus,    // Peripheral pair D+ level
  input  wire logic i_periph_side_dminus,   // Peripheral pair D- level
  input  wire logic i_hs_bit_valid,         // HS recovered bit strobe
  input  wire logic i_hs_bit,               // HS recovered NRZI-decoded bit
  output logic      o_host_side_dplus,      // Host pair D+ drive
  output logic      o_host_side_dminus,     // Host pair D- drive
  output logic      o_host_side_oe,         // Host pair drive enable
  output logic      o_periph_side_dplus,    // Peripheral pair D+ drive
  output logic      o_periph_side_dminus,   // Peripheral pair D- drive
  output logic      o_periph_side_oe,       // Peripheral pair drive enable
  output logic      o_host_side_hs_term,    // Host pair 45 ohm terminations on
  output logic      o_periph_side_hs_term,  // Peripheral pair 45 ohm terminations on
  output logic [1:0] o_speed,               // Negotiated speed
  output logic [1:0] o_dir,                 // 0 idle, 1 downstream, 2 upstream
  output logic      o_eop                   // End of packet pulse
);

  //--------------------------------------------------------------------
  // Synchronised inputs
  //--------------------------------------------------------------------
  ulsd_if sync_bus ();

  ulsd_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pins    ({i_host_side_dplus, i_host_side_dminus, i_periph_side_dplus, i_periph_side_dminus}),
    .o_sync    (sync_bus)
  );

  //--------------------------------------------------------------------
  // Speed and handshake state
  //--------------------------------------------------------------------
  typedef enum logic [2:0] {ST_DETACH, ST_FS_LS, ST_CHIRP_K, ST_HOST_KJ, ST_HS} ulsd_neg_e;
  typedef enum logic [1:0] {DIR_IDLE, DIR_DOWN, DIR_UP} ulsd_dir_e;

  ulsd_neg_e   neg_q, neg_d;       // Handshake progress
  ulsd_speed_e spd_q, spd_d;       // Current speed
  ulsd_dir_e   dir_q, dir_d;       // Transfer direction
  logic [2:0]  kj_cnt_q, kj_cnt_d; // KJ pairs seen from host
  logic        last_k_q;           // Host last showed K in chirp
  logic [7:0]  idle_q;             // Idle cycle counter
  logic [2:0]  ones_q;             // HS ones run
  ulsd_line_e  h_prev_q, p_prev_q; // Previous classifications

  // Current classifications
  wire ulsd_line_e h_ls = ulsd_classify(sync_bus.host_side_dplus, sync_bus.host_side_dminus, spd_q);
  wire ulsd_line_e p_ls = ulsd_classify(sync_bus.periph_side_dplus, sync_bus.periph_side_dminus, spd_q);

  // Idle per speed: J at LS/FS, no differential (SE0) at HS
  wire ulsd_line_e idle_ls = (spd_q == SPD_HIGH) ? LS_SE0 : LS_J;        // R16 R10
  wire h_idle = (h_ls == idle_ls);
  wire p_idle = (p_ls == idle_ls);
  wire h_act  = (h_ls != h_prev_q) && (h_prev_q == idle_ls) && (h_ls != LS_SE1); // R17
  wire p_act  = (p_ls != p_prev_q) && (p_prev_q == idle_ls) && (p_ls != LS_SE1); // R17

  // End of packet detectors
  wire lsfs_eop = (spd_q != SPD_HIGH) && (spd_q != SPD_NONE)
                  && (h_prev_q == LS_SE0 || p_prev_q == LS_SE0)
                  && ((dir_q == DIR_DOWN && h_ls == LS_J) || (dir_q == DIR_UP && p_ls == LS_J)); // R08 R14
  wire hs_eop   = (spd_q == SPD_HIGH) && i_hs_bit_valid && i_hs_bit
                  && (ones_q == HS_ONES_EOP - 3'h1);                     // R09
  wire idle_to  = (idle_q == IDLE_CYC_T);

  //--------------------------------------------------------------------
  // Negotiation: attach polarity, chirp, KJ count
  //--------------------------------------------------------------------
  always_comb begin
    neg_d    = neg_q;
    spd_d    = spd_q;
    kj_cnt_d = kj_cnt_q;
    unique case (neg_q)
      ST_DETACH: begin
        if (sync_bus.periph_side_dminus && !sync_bus.periph_side_dplus) begin
          spd_d = SPD_LOW;                // R02
          neg_d = ST_FS_LS;
        end else if (sync_bus.periph_side_dplus && !sync_bus.periph_side_dminus) begin
          spd_d = SPD_FULL;               // R03
          neg_d = ST_FS_LS;
        end
      end
      ST_FS_LS: begin
        // Peripheral K during host reset SE0 is the chirp
        if (spd_q == SPD_FULL && h_ls == LS_SE0 && p_ls == LS_K) begin
          neg_d    = ST_CHIRP_K;          // R04
          kj_cnt_d = 3'h0;
        end
      end
      ST_CHIRP_K: begin
        // Full speed host ignores it; host K start means HS host
        if (h_ls == LS_K && p_ls != LS_K) begin
          neg_d = ST_HOST_KJ;             // R05
        end else if (p_ls == LS_J) begin
          neg_d = ST_FS_LS;               // R05
        end
      end
      ST_HOST_KJ: begin
        if (h_ls == LS_J && last_k_q && kj_cnt_q != 3'h7) begin
          kj_cnt_d = kj_cnt_q + 3'h1;
        end
        if (kj_cnt_q >= CHIRP_PAIRS_MIN) begin
          neg_d = ST_HS;                  // R06
          spd_d = SPD_HIGH;
        end
      end
      ST_HS: begin
      end
    endcase
  end

  // Host SE0 at LS/FS is bus reset, not a packet; locking a direction then would hide the chirp
  wire bus_rst = (spd_q != SPD_HIGH) && (h_ls == LS_SE0);
  // Direction may only start in a settled speed, never during the chirp handshake
  wire dir_ok  = ((neg_q == ST_FS_LS) || (neg_q == ST_HS)) && !bus_rst;

  //--------------------------------------------------------------------
  // Direction control
  //--------------------------------------------------------------------
  always_comb begin
    dir_d = dir_q;
    if (dir_q == DIR_IDLE && dir_ok) begin
      if (h_act) begin
        dir_d = DIR_DOWN;                 // R17
      end else if (p_act) begin
        dir_d = DIR_UP;                   // R17
      end
    end else if (lsfs_eop || hs_eop || idle_to) begin
      dir_d = DIR_IDLE;                   // R17
    end
  end

  //--------------------------------------------------------------------
  // State registers
  //--------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      neg_q    <= ST_DETACH;
      spd_q    <= SPD_NONE;
      dir_q    <= DIR_IDLE;
      kj_cnt_q <= 3'h0;
      last_k_q <= 1'b0;
      h_prev_q <= LS_SE0;
      p_prev_q <= LS_SE0;
    end else begin
      neg_q    <= neg_d;
      spd_q    <= spd_d;
      dir_q    <= dir_d;
      kj_cnt_q <= kj_cnt_d;
      last_k_q <= (h_ls == LS_K) ? 1'b1 : ((h_ls == LS_J) ? 1'b0 : last_k_q);
      h_prev_q <= h_ls;
      p_prev_q <= p_ls;
    end
  end

  //--------------------------------------------------------------------
  // Idle timer and HS ones counter
  //--------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_q <= 8'h00;
      ones_q <= 3'h0;
    end else begin
      // Counts only while a direction is held, so it cannot free-run
      idle_q <= (dir_q != DIR_IDLE && h_idle && p_idle && !idle_to) ? idle_q + 8'h01 : 8'h00;
      if (i_hs_bit_valid) begin
        ones_q <= (i_hs_bit && ones_q != HS_ONES_EOP) ? ones_q + 3'h1 : 3'h0; // R09
      end
    end
  end

  //--------------------------------------------------------------------
  // Repeat path: copy input pair to output pair, SE1 replaced by SE0
  //--------------------------------------------------------------------
  wire h_se1 = (h_ls == LS_SE1);
  wire p_se1 = (p_ls == LS_SE1);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_side_dplus    <= 1'b0;
      o_host_side_dminus   <= 1'b0;
      o_host_side_oe       <= 1'b0;
      o_periph_side_dplus  <= 1'b0;
      o_periph_side_dminus <= 1'b0;
      o_periph_side_oe     <= 1'b0;
    end else begin
      o_periph_side_oe     <= (dir_d == DIR_DOWN);                                  // R01
      o_periph_side_dplus  <= sync_bus.host_side_dplus && !h_se1;                   // R01 R15
      o_periph_side_dminus <= sync_bus.host_side_dminus && !h_se1;                  // R15
      o_host_side_oe       <= (dir_d == DIR_UP);                                    // R01
      o_host_side_dplus    <= sync_bus.periph_side_dplus && !p_se1;                 // R15
      o_host_side_dminus   <= sync_bus.periph_side_dminus && !p_se1;                // R15
    end
  end

  //--------------------------------------------------------------------
  // Terminations: host side from host KJ on, peripheral side once HS
  //--------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_side_hs_term   <= 1'b0;
      o_periph_side_hs_term <= 1'b0;
      o_speed               <= SPD_NONE;
      o_dir                 <= 2'h0;
      o_eop                 <= 1'b0;
    end else begin
      o_host_side_hs_term   <= (neg_d == ST_HOST_KJ) || (neg_d == ST_HS); // R07
      o_periph_side_hs_term <= (neg_d == ST_HS);                          // R07
      o_speed               <= spd_d;
      o_dir                 <= dir_d;
      o_eop                 <= lsfs_eop || hs_eop;                        // R08 R09
    end
  end

endmodule

/* sim/ulsd_monitor.sv */
/* Checker for ulsd_top: watches only the top ports.
   Assumes one clock domain and the 3-edge pin-to-output latency. */
`timescale 1ns/1ps
module ulsd_monitor
  import ulsd_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       i_host_side_dplus,
  input wire logic       i_host_side_dminus,
  input wire logic       i_periph_side_dplus,
  input wire logic       i_periph_side_dminus,
  input wire logic       i_hs_bit_valid,
  input wire logic       i_hs_bit,
  input wire logic       o_host_side_dplus,
  input wire logic       o_host_side_dminus,
  input wire logic       o_host_side_oe,
  input wire logic       o_periph_side_dplus,
  input wire logic       o_periph_side_dminus,
  input wire logic       o_periph_side_oe,
  input wire logic       o_host_side_hs_term,
  input wire logic       o_periph_side_hs_term,
  input wire logic [1:0] o_speed,
  input wire logic [1:0] o_dir,
  input wire logic       o_eop
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // -------------------------------------------
  // Sequences
  // -------------------------------------------
  sequence s_seven_ones;
    (i_hs_bit_valid && !i_hs_bit) ##1 (i_hs_bit_valid && i_hs_bit)[*7];
  endsequence
  sequence s_quiet;
    (!i_hs_bit_valid)[*4];
  endsequence
  // -------------------------------------------
  // Properties
  // -------------------------------------------
  property p_se1_host;
    o_host_side_oe |-> !(o_host_side_dplus && o_host_side_dminus);
  endproperty
  a_se1_host: assert property (p_se1_host) else $error("SE1 on host pair");
  property p_down_copy;
    o_periph_side_oe |-> o_periph_side_dplus == ($past(i_host_side_dplus, 3) && !$past(i_host_side_dminus, 3))
      && o_periph_side_dminus == ($past(i_host_side_dminus, 3) && !$past(i_host_side_dplus, 3));
  endproperty
  a_down_copy: assert property (p_down_copy) else $error("downstream copy wrong");
  property p_up_copy;
    o_host_side_oe |-> o_host_side_dplus == ($past(i_periph_side_dplus, 3) && !$past(i_periph_side_dminus, 3))
      && o_host_side_dminus == ($past(i_periph_side_dminus, 3) && !$past(i_periph_side_dplus, 3));
  endproperty
  a_up_copy: assert property (p_up_copy) else $error("upstream copy wrong");
  property p_dir_oe;
    o_periph_side_oe == (o_dir == 2'h1) && o_host_side_oe == (o_dir == 2'h2);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("enable disagrees with direction");
  property p_eop_pulse;
    o_eop |=> !o_eop;
  endproperty
  a_eop_pulse: assert property (p_eop_pulse) else $error("end of packet too long");
  property p_fs_attach;
    $rose(o_speed == SPD_FULL) |-> $past(i_periph_side_dplus, 3) && !$past(i_periph_side_dminus, 3);
  endproperty
  a_fs_attach: assert property (p_fs_attach) else $error("full speed without D+ pull-up");
  property p_ls_attach;
    $rose(o_speed == SPD_LOW) |-> $past(i_periph_side_dminus, 3) && !$past(i_periph_side_dplus, 3);
  endproperty
  a_ls_attach: assert property (p_ls_attach) else $error("low speed without D- pull-up");
  property p_hs_eop;
    (o_speed == SPD_HIGH) ##0 s_seven_ones |-> ##[0:3] o_eop;
  endproperty
  a_hs_eop: assert property (p_hs_eop) else $error("seven ones gave no end of packet");
  property p_hs_idle;
    (o_speed == SPD_HIGH) throughout s_quiet |-> !o_eop;
  endproperty
  a_hs_idle: assert property (p_hs_idle) else $error("end of packet on idle");
  property p_term;
    o_periph_side_hs_term |-> o_host_side_hs_term;
  endproperty
  a_term: assert property (p_term) else $error("terminations not mirrored");
endmodule
bind ulsd_top ulsd_monitor i_ulsd_monitor (.*);

/* sim/ulsd_partner.sv */
/* Host and peripheral line model with a high speed chirp responder.
   Assumes pairs as {D+,D-}; a driving design side wins the wire. */
`timescale 1ns/1ps
module ulsd_partner (
  input  wire logic       clk,
  input  wire logic       hs_host,
  input  wire logic [3:0] n_pairs,
  input  wire logic [1:0] h_drv,
  input  wire logic [1:0] p_drv,
  input  wire logic [1:0] dut_h,
  input  wire logic [1:0] dut_p,
  input  wire logic       dut_h_oe,
  input  wire logic       dut_p_oe,
  output logic      [1:0] h_pin,
  output logic      [1:0] p_pin
);
  logic [2:0] cnt;
  logic [1:0] ph;
  logic [3:0] sent;
  logic       busy;
  logic       done;
  // Chirp K seen during bus reset starts KJ pairs; a full speed host stays quiet
  always_ff @(posedge clk) begin
    if (!hs_host) begin
      {cnt, ph, sent, busy, done} <= '0;
    end else if (busy) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        sent <= sent + 4'h1;
        busy <= (sent + 4'h1 != n_pairs);
        done <= (sent + 4'h1 == n_pairs);
      end
    end else if (!done && h_drv == 2'h0) begin
      // Count the chirp K; answer with KJ pairs once it has ended
      if (p_drv == 2'h1 && cnt != 3'h7) cnt <= cnt + 3'h1;
      busy <= (p_drv != 2'h1) && (cnt >= 3'h4);
    end
  end
  assign h_pin = dut_h_oe ? dut_h : (busy ? (ph[1] ? 2'h2 : 2'h1) : h_drv);
  assign p_pin = dut_p_oe ? dut_p : p_drv;
endmodule

/* sim/ulsd_top_tb.sv */
/* Self-checking bench for ulsd_top.
   Assumes a 10 MHz clock and the 30-cycle idle release. */
`timescale 1ns/1ps
module ulsd_top_tb;
  import ulsd_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, hs_host = 1'b0, hbv = 1'b0, hb = 1'b0;
  logic [1:0] h_drv = 2'h2, p_drv = 2'h2, h_pin, p_pin, spd, dir;
  logic [3:0] n_pairs = 4'h3;
  logic       ohp, ohm, ohoe, opp, opm, opoe, oht, opt, eop, e;
  int         n_mismatch = 0, num_checks = 0;
  always #50 clk = ~clk;
  ulsd_partner i_ulsd_partner (.clk(clk), .hs_host(hs_host), .n_pairs(n_pairs), .h_drv(h_drv), .p_drv(p_drv),
    .dut_h({ohp, ohm}), .dut_p({opp, opm}), .dut_h_oe(ohoe), .dut_p_oe(opoe), .h_pin(h_pin), .p_pin(p_pin));
  ulsd_top i_ulsd_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_host_side_dplus(h_pin[1]),
    .i_host_side_dminus(h_pin[0]), .i_periph_side_dplus(p_pin[1]), .i_periph_side_dminus(p_pin[0]),
    .i_hs_bit_valid(hbv), .i_hs_bit(hb), .o_host_side_dplus(ohp), .o_host_side_dminus(ohm),
    .o_host_side_oe(ohoe), .o_periph_side_dplus(opp), .o_periph_side_dminus(opm), .o_periph_side_oe(opoe),
    .o_host_side_hs_term(oht), .o_periph_side_hs_term(opt), .o_speed(spd), .o_dir(dir), .o_eop(eop));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Sample just after the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic watch(input int n);
    e = 1'b0;
    #1;
    e = eop;
    repeat (n) begin
      cyc(1);
      e |= eop;
    end
  endtask
  task automatic drv(input logic [1:0] h, input logic [1:0] p);
    @(posedge clk);
    h_drv <= h;
    p_drv <= p;
  endtask
  task automatic do_reset(input logic [1:0] h, input logic [1:0] p);
    @(posedge clk);
    rst_n <= 1'b0;
    hs_host <= 1'b0;
    h_drv <= h;
    p_drv <= p;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(5);
  endtask
  // Packet one way: K, then SE1, then SE0 and J
  task automatic t_packet(input logic [1:0] k, input logic [1:0] j, input logic up);
    if (up) drv(j, k); else drv(k, j);
    cyc(4);
    chk(8'(dir), up ? 8'h2 : 8'h1);
    chk(8'(up ? {ohp, ohm} : {opp, opm}), 8'(k));
    if (up) drv(j, 2'h3); else drv(2'h3, j);
    cyc(4);
    chk(8'(up ? {ohp, ohm} : {opp, opm}), 8'h0);
    if (up) drv(j, 2'h0); else drv(2'h0, j);
    cyc(2);
    drv(j, j);
    watch(6);
    chk(8'(e), 8'h1);
    cyc(2);
    chk(8'(dir), 8'h0);
  endtask
  task automatic t_idle();
    drv(2'h1, 2'h2);
    cyc(4);
    drv(2'h2, 2'h2);
    cyc(20);
    chk(8'(dir), 8'h1);
    cyc(17);
    chk(8'(dir), 8'h0);
  endtask
  // Chirp handshake with a given number of host KJ pairs
  task automatic t_hs(input logic [3:0] pairs);
    do_reset(2'h2, 2'h2);
    chk(8'(spd), 8'(SPD_FULL));
    drv(2'h0, 2'h2);
    cyc(40);
    @(posedge clk);
    n_pairs <= pairs;
    hs_host <= 1'b1;
    p_drv <= 2'h1;
    cyc(10);
    @(posedge clk);
    p_drv <= 2'h0;
    cyc(40);
    chk(8'(spd), (pairs >= 4'h3) ? 8'(SPD_HIGH) : 8'(SPD_FULL));
    chk(8'(opt), 8'(pairs >= 4'h3));
    chk(8'(oht), 8'h1);
    if (pairs >= 4'h3) begin
      @(posedge clk);
      hbv <= 1'b1;
      hb <= 1'b0;
      repeat (7) @(posedge clk) hb <= 1'b1;
      @(posedge clk);
      hbv <= 1'b0;
      watch(5);
      chk(8'(e), 8'h1);
      watch(20);
      chk(8'(e), 8'h0);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    do_reset(2'h2, 2'h2);
    chk(8'(spd), 8'(SPD_FULL));
    t_packet(2'h1, 2'h2, 1'b0);
    t_packet(2'h1, 2'h2, 1'b1);
    t_idle();
    do_reset(2'h1, 2'h1);
    chk(8'(spd), 8'(SPD_LOW));
    t_packet(2'h2, 2'h1, 1'b0);
    t_packet(2'h2, 2'h1, 1'b1);
    t_hs(4'h2);
    t_hs(4'h3);
    results();
  end
  initial begin
    #(20000 * 100);
    n_mismatch++;
    results();
  end
endmodule
